// ===== apt_top.sv
// two-pin address port with pin function select and external interrupt triggers
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
`include "apt_regs.svh"
module apt_top
    import apt_pkg::*;
#(
    parameter int NPIN = `APT_NPIN,
    parameter int LVL_DIV = `APT_LVL_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NPIN-1:0] addr_bit_i,
    input wire logic [NPIN-1:0] irq_ack_i,
    input wire logic [NPIN-1:0] pin_i,
    output logic [NPIN-1:0] pin_o,
    output logic [NPIN-1:0] pin_oe_o,
    output logic [NPIN-1:0] irq_req_o
);

    // last count of the level strobe divider
    localparam logic [`APT_LVL_CNT_W-1:0] LVL_LAST = `APT_LVL_CNT_W'(LVL_DIV - 1);

    // software-visible configuration
    logic [NPIN-1:0] port_data_ff;
    logic [NPIN-1:0] port_dir_ff;
    logic [NPIN-1:0] mode_ctl_ff;
    logic [NPIN-1:0] func_sel_ff;
    logic [NPIN-1:0] fall_sel_ff;
    logic [NPIN-1:0] rise_sel_ff;

    // request flags and pin drive
    logic [NPIN-1:0] req_flag_ff;
    logic [NPIN-1:0] nxt_req_flag;
    logic [NPIN-1:0] pin_out_ff;
    logic [NPIN-1:0] pin_oe_ff;
    logic [NPIN-1:0] nxt_pin_out;
    logic [NPIN-1:0] nxt_pin_oe;

    // trigger path and level strobe
    logic [NPIN-1:0] trig_set;
    logic [NPIN-1:0] pin_level;
    logic [`APT_LVL_CNT_W-1:0] lvl_cnt_ff;
    logic lvl_sample;

    // register bus
    logic ack_ff;
    logic [31:0] rd_data_ff;
    logic [31:0] nxt_rd_data;
    apt_wb_req_t req;
    logic [7:0] wr_byte;
    logic wr_port_data;
    logic wr_port_dir;
    logic wr_mode_ctl;
    logic wr_func_sel;
    logic wr_fall_sel;
    logic wr_rise_sel;
    logic wr_irq_ctl;
    logic [NPIN-1:0] flag_clr;
    logic [NPIN-1:0] flag_set;

    // bus request gathered once, write takes effect on the acking edge
    always_comb begin
        req.adr = adr_i;
        req.dat = dat_i;
        req.sel = sel_i;
        req.we = we_i;
        req.req = cyc_i && stb_i && !ack_ff;
    end

    assign wr_byte = req.dat[7:0];

    function automatic logic hit(input logic [31:0] adr, input logic [31:0] reg_adr);
        return adr == reg_adr;
    endfunction

    // a write lands only on the taking edge and only through byte lane 0
    function automatic logic wr_hit(input apt_wb_req_t r, input logic [31:0] reg_adr);
        return r.req && r.we && r.sel[0] && hit(r.adr, reg_adr);
    endfunction

    // one write strobe per register
    always_comb begin
        wr_port_data = wr_hit(req, `APT_ADR_PORT_DATA);
        wr_port_dir = wr_hit(req, `APT_ADR_PORT_DIR);
        wr_mode_ctl = wr_hit(req, `APT_ADR_MODE_CTL);
        wr_func_sel = wr_hit(req, `APT_ADR_FUNC_SEL);
        wr_fall_sel = wr_hit(req, `APT_ADR_FALL_SEL);
        wr_rise_sel = wr_hit(req, `APT_ADR_RISE_SEL);
        wr_irq_ctl = wr_hit(req, `APT_ADR_IRQ_CTL);
    end

    // narrow registers read in the low byte, upper bits zero except port direction bits 7:2, which read as one
    function automatic logic [31:0] widen(input logic [NPIN-1:0] val);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[NPIN-1:0] = val;
        return w;
    endfunction

    // single-cycle ack, one idle cycle forced between accesses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req.req;
        end
    end

    // unmapped addresses still ack and read as zero
    always_comb begin
        nxt_rd_data = 32'h0000_0000;
        if (hit(req.adr, `APT_ADR_PORT_DATA)) begin
            nxt_rd_data = widen((port_data_ff & ~port_dir_ff) | (pin_level & port_dir_ff));
        end else if (hit(req.adr, `APT_ADR_PORT_DIR)) begin
            nxt_rd_data = widen(port_dir_ff) | 32'h0000_00fc;
        end else if (hit(req.adr, `APT_ADR_MODE_CTL)) begin
            nxt_rd_data = widen(mode_ctl_ff);
        end else if (hit(req.adr, `APT_ADR_FUNC_SEL)) begin
            nxt_rd_data = widen(func_sel_ff);
        end else if (hit(req.adr, `APT_ADR_FALL_SEL)) begin
            nxt_rd_data = widen(fall_sel_ff);
        end else if (hit(req.adr, `APT_ADR_RISE_SEL)) begin
            nxt_rd_data = widen(rise_sel_ff);
        end else if (hit(req.adr, `APT_ADR_IRQ_CTL)) begin
            nxt_rd_data = widen(req_flag_ff);
        end
    end

    // read data held between reads, so dat_o stays put outside ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_ff <= 32'h0000_0000;
        end else if (req.req && !req.we) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // port data latch, driven in port mode with output direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_data_ff <= NPIN'(`APT_RST_PORT_DATA);
        end else if (wr_port_data) begin
            port_data_ff <= wr_byte[NPIN-1:0];
        end
    end

    // direction: 1 input, 0 output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_dir_ff <= NPIN'(`APT_RST_PORT_DIR);
        end else if (wr_port_dir) begin
            port_dir_ff <= wr_byte[NPIN-1:0];
        end
    end

    // mode must be set before the triggers; changing it later may raise a false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ctl_ff <= NPIN'(`APT_RST_MODE_CTL);
        end else if (wr_mode_ctl) begin
            mode_ctl_ff <= wr_byte[NPIN-1:0];
        end
    end

    // bit operations arrive as byte read-modify-write from the cpu
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_sel_ff <= NPIN'(`APT_RST_FUNC_SEL);
        end else if (wr_func_sel) begin
            func_sel_ff <= wr_byte[NPIN-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fall_sel_ff <= NPIN'(`APT_RST_FALL_SEL);
        end else if (wr_fall_sel) begin
            fall_sel_ff <= wr_byte[NPIN-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_sel_ff <= NPIN'(`APT_RST_RISE_SEL);
        end else if (wr_rise_sel) begin
            rise_sel_ff <= wr_byte[NPIN-1:0];
        end
    end

    // level sample strobe, one clock in every LVL_DIV
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_cnt_ff <= '0;
        end else if (lvl_cnt_ff == LVL_LAST) begin
            lvl_cnt_ff <= '0;
        end else begin
            lvl_cnt_ff <= lvl_cnt_ff + 1'b1;
        end
    end

    // a low pulse between two strobes is missed; level sources must hold low
    assign lvl_sample = lvl_cnt_ff == LVL_LAST;

    // one detector per line, each with its own bit of every select register
    for (genvar i = 0; i < NPIN; i++) begin : g_line
        apt_pin_cfg_t cfg;
        always_comb begin
            cfg.mode_ctl = mode_ctl_ff[i];
            cfg.func_sel = func_sel_ff[i];
            cfg.fall_sel = fall_sel_ff[i];
            cfg.rise_sel = rise_sel_ff[i];
        end
        apt_trig u_trig (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(pin_i[i]),
            .sample_i(lvl_sample),
            .cfg_i(cfg),
            .set_o(trig_set[i]),
            .level_o(pin_level[i])
        );
    end

    // clear sources: cpu acknowledge or a software write of zero
    always_comb begin
        flag_clr = irq_ack_i;
        if (wr_irq_ctl) begin
            flag_clr = irq_ack_i | ~wr_byte[NPIN-1:0];
        end
    end

    // set sources: a detected trigger or a software write of one
    always_comb begin
        flag_set = trig_set;
        if (wr_irq_ctl) begin
            flag_set = trig_set | wr_byte[NPIN-1:0];
        end
    end

    // a set in the same cycle as a clear wins, so no trigger is lost
    assign nxt_req_flag = (req_flag_ff & ~flag_clr) | flag_set;

    // flag holds until cleared, regardless of the pin going inactive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_flag_ff <= NPIN'(`APT_RST_IRQ_CTL);
        end else begin
            req_flag_ff <= nxt_req_flag;
        end
    end

    // pin drive per mode
    always_comb begin
        nxt_pin_out = '0;
        nxt_pin_oe = '0;
        for (int i = 0; i < NPIN; i++) begin
            if (!mode_ctl_ff[i]) begin
                nxt_pin_out[i] = port_data_ff[i];
                nxt_pin_oe[i] = !port_dir_ff[i];
            end else if (func_sel_ff[i]) begin
                nxt_pin_out[i] = addr_bit_i[i];
                nxt_pin_oe[i] = 1'b1;
            end
        end
    end

    // registered drive adds one clock of latency to the address bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    // every output comes straight from a flop
    assign dat_o = rd_data_ff;
    assign ack_o = ack_ff;
    assign pin_o = pin_out_ff;
    assign pin_oe_o = pin_oe_ff;
    assign irq_req_o = req_flag_ff;

endmodule

// ===== apt_regs.svh
// register offsets, reset values and timing counts of the address port trigger block
`ifndef APT_REGS_SVH
`define APT_REGS_SVH

`define APT_ADR_PORT_DATA 32'hffff_f000
`define APT_ADR_PORT_DIR 32'hffff_f020
`define APT_ADR_MODE_CTL 32'hffff_f040
`define APT_ADR_FUNC_SEL 32'hffff_f058
`define APT_ADR_FALL_SEL 32'hffff_fc10
`define APT_ADR_RISE_SEL 32'hffff_fc30
`define APT_ADR_IRQ_CTL 32'hffff_f100

`define APT_RST_PORT_DATA 8'h00
`define APT_RST_PORT_DIR 8'hff
`define APT_RST_MODE_CTL 8'h02
`define APT_RST_FUNC_SEL 8'h03
`define APT_RST_FALL_SEL 8'h00
`define APT_RST_RISE_SEL 8'h03
`define APT_RST_IRQ_CTL 8'h00

`define APT_NPIN 2
`define APT_LVL_DIV 4
`define APT_LVL_CNT_W 2

`endif

// ===== apt_pkg.sv
// types shared by the address port trigger block
package apt_pkg;

    typedef enum logic [1:0] {
        APT_TRIG_FALL,
        APT_TRIG_RISE,
        APT_TRIG_LEVEL,
        APT_TRIG_BOTH
    } apt_trig_t;

    typedef struct packed {
        logic mode_ctl;
        logic func_sel;
        logic fall_sel;
        logic rise_sel;
    } apt_pin_cfg_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic req;
    } apt_wb_req_t;

    // fall and rise select bits to trigger mode
    function automatic apt_trig_t apt_trig_decode(input logic fall_sel, input logic rise_sel);
        apt_trig_t mode;
        mode = APT_TRIG_FALL;
        if (fall_sel && rise_sel) begin
            mode = APT_TRIG_BOTH;
        end else if (fall_sel) begin
            mode = APT_TRIG_LEVEL;
        end else if (rise_sel) begin
            mode = APT_TRIG_RISE;
        end
        return mode;
    endfunction

endpackage

// ===== apt_trig.sv
// per-pin synchroniser and trigger detector
`timescale 1ns/10ps
module apt_trig
    import apt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic sample_i,
    input wire apt_pin_cfg_t cfg_i,
    output logic set_o,
    output logic level_o
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic irq_en;
    apt_trig_t mode;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
        end
    end

    // previous sample taken from the second stage only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    always_comb begin
        // function bit only counts in control mode
        irq_en = cfg_i.mode_ctl && !cfg_i.func_sel;
        mode = apt_trig_decode(cfg_i.fall_sel, cfg_i.rise_sel);
        set_o = 1'b0;
        if (irq_en) begin
            case (mode)
                APT_TRIG_FALL: set_o = prev_ff && !sync_ff;
                APT_TRIG_RISE: set_o = !prev_ff && sync_ff;
                APT_TRIG_BOTH: set_o = prev_ff != sync_ff;
                APT_TRIG_LEVEL: set_o = sample_i && !sync_ff;
                default: set_o = 1'b0;
            endcase
        end
    end

    assign level_o = sync_ff;

endmodule

// ===== apt_top_asserts.sv
// port assertions for the address port trigger block
`timescale 1ns/10ps
`include "apt_regs.svh"
module apt_top_asserts
    import apt_pkg::*;
#(
    parameter int NPIN = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [NPIN-1:0] addr_bit_i,
    input wire logic [NPIN-1:0] irq_ack_i,
    input wire logic [NPIN-1:0] pin_i,
    input wire logic [NPIN-1:0] pin_o,
    input wire logic [NPIN-1:0] pin_oe_o,
    input wire logic [NPIN-1:0] irq_req_o
);
    logic [1:0] mode_ff, func_ff, fall_ff, rise_ff;
    logic wr, clr0;
    // shadow config, updated at the edge that takes the write
    assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign clr0 = irq_ack_i[0] || (wr && adr_i == `APT_ADR_IRQ_CTL);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= 2'(`APT_RST_MODE_CTL);
            func_ff <= 2'(`APT_RST_FUNC_SEL);
            fall_ff <= 2'(`APT_RST_FALL_SEL);
            rise_ff <= 2'(`APT_RST_RISE_SEL);
        end else if (wr) begin
            case (adr_i)
                `APT_ADR_MODE_CTL: mode_ff <= dat_i[1:0];
                `APT_ADR_FUNC_SEL: func_ff <= dat_i[1:0];
                `APT_ADR_FALL_SEL: fall_ff <= dat_i[1:0];
                `APT_ADR_RISE_SEL: rise_ff <= dat_i[1:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_fall0;
        mode_ff[0] && !func_ff[0] && !fall_ff[0] && !rise_ff[0] && $fell(pin_i[0]);
    endsequence
    sequence s_low0;
        (mode_ff[0] && !func_ff[0] && fall_ff[0] && !rise_ff[0] && !pin_i[0])[*8];
    endsequence
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    a_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && !(adr_i inside {
        `APT_ADR_PORT_DATA, `APT_ADR_PORT_DIR, `APT_ADR_MODE_CTL, `APT_ADR_FUNC_SEL,
        `APT_ADR_FALL_SEL, `APT_ADR_RISE_SEL, `APT_ADR_IRQ_CTL}) |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_addr_drive: assert property (mode_ff[0] && func_ff[0] && $stable(mode_ff) &&
        $stable(func_ff) && !$past(rst_i) |-> pin_oe_o[0] && pin_o[0] == $past(addr_bit_i[0]))
        else $error("address pin not driven");
    a_irq_undriven: assert property (mode_ff[1] && !func_ff[1] && $stable(mode_ff) &&
        $stable(func_ff) && !$past(rst_i) |-> !pin_oe_o[1])
        else $error("interrupt pin driven");
    a_fall_edge: assert property (s_fall0 |-> ##[2:5] irq_req_o[0])
        else $error("falling edge lost");
    a_level_repeat: assert property (s_low0 ##0 irq_ack_i[0] |-> ##[1:6] irq_req_o[0])
        else $error("level request not repeated");
    a_flag_held: assert property (irq_req_o[0] && !clr0 && !$past(clr0) |=> irq_req_o[0])
        else $error("pending request lost");
endmodule

// ===== apt_irq_src.sv
// external sources that pull the interrupt lines low
`timescale 1ns/10ps
module apt_irq_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] act_i,
    input wire logic slow_i,
    output logic [1:0] line_o
);
    logic [1:0] d1_ff, d2_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d1_ff <= 2'h0;
            d2_ff <= 2'h0;
        end else begin
            d1_ff <= act_i;
            d2_ff <= d1_ff;
        end
    end
    // a slow source lags its service command by one more clock
    // lines have pull-ups, so a released line reads high
    assign line_o = ~(slow_i ? d2_ff : d1_ff);
endmodule

// ===== apt_top_test.sv
// self-checking bench for the address port trigger block
`timescale 1ns/10ps
`include "apt_regs.svh"
module apt_top_test
    import apt_pkg::*;
;
    localparam int MD = `APT_ADR_MODE_CTL;
    localparam int FN = `APT_ADR_FUNC_SEL;
    localparam int FL = `APT_ADR_FALL_SEL;
    localparam int RS = `APT_ADR_RISE_SEL;
    localparam int IQ = `APT_ADR_IRQ_CTL;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] addr_bit_i = 2'h0, irq_ack_i = 2'h0, act = 2'h0;
    logic [1:0] pin_i, pin_o, pin_oe_o, irq_req_o;
    logic [31:0] dat_o;
    logic ack_o;
    logic slow = 1'b0;
    apt_wb_req_t req = '0;
    logic [7:0] rd;
    logic [7:0] mdl [int];
    int seed = 52014;
    int failures = 0;
    int n_compared = 0;
    apt_top #(.NPIN(2), .LVL_DIV(4)) apt_top_inst (
        .clk_i, .rst_i, .cyc_i(req.req), .stb_i(req.req), .we_i(req.we), .adr_i(req.adr),
        .sel_i(req.sel), .dat_i(req.dat), .dat_o, .ack_o, .addr_bit_i, .irq_ack_i,
        .pin_i, .pin_o, .pin_oe_o, .irq_req_o
    );
    apt_irq_src apt_irq_src_inst (.clk_i, .rst_i, .act_i(act), .slow_i(slow), .line_o(pin_i));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        addr_bit_i <= 2'($random(seed));
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bits(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask
    // classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input int a, input logic [7:0] d, input logic [3:0] s);
        int i;
        @(posedge clk_i);
        req <= '{32'(a), {24'h00_0000, d}, s, w, 1'b1};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        rd = dat_o[7:0];
        req <= '0;
        if (ack_o !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic wr(input int a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
        if (mdl.exists(a)) begin
            mdl[a] = d & 8'h03;
        end
    endtask
    task automatic rdc(input int a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'h1);
        cmp_reg($sformatf("reg %h", a), e, rd);
    endtask
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    initial begin
        int m0;
        int m1;
        logic [1:0] e;
        mdl[MD] = `APT_RST_MODE_CTL;
        mdl[FN] = `APT_RST_FUNC_SEL;
        mdl[FL] = `APT_RST_FALL_SEL;
        mdl[RS] = `APT_RST_RISE_SEL;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (mdl[a]) begin
            rdc(a, mdl[a]);
            wr(a, 8'($random(seed)));
            rdc(a, mdl[a]);
        end
        wb(1'b1, FN, ~mdl[FN], 4'h2);
        rdc(FN, mdl[FN]);
        wb(1'b0, RS, 8'h00, 4'h1);
        wr(RS, rd ^ 8'h02);
        rdc(RS, mdl[RS]);
        wr(32'hffff_f060, 8'hff);
        rdc(32'hffff_f060, 8'h00);
        wr(MD, 8'h03);
        wr(FN, 8'h01);
        repeat (3) @(posedge clk_i);
        e = addr_bit_i;
        @(posedge clk_i);
        cmp_bits("oe", 2'b01, pin_oe_o);
        cmp_bits("addr", e & 2'b01, pin_o & 2'b01);
        wr(MD, 8'h00);
        repeat (3) @(posedge clk_i);
        cmp_bits("oe", 2'b00, pin_oe_o);
        wr(MD, 8'h03);
        wr(FN, 8'h00);
        for (int m = 0; m < 4; m++) begin
            m0 = m;
            m1 = (m + 1) % 4;
            slow <= m0[0];
            wr(FL, 8'({m1[1], m0[1]}));
            wr(RS, 8'({m1[0], m0[0]}));
            wr(IQ, 8'h00);
            act <= 2'b11;
            repeat (12) @(posedge clk_i);
            e = {m1 != 1, m0 != 1};
            cmp_bits("low", e, irq_req_o);
            act <= 2'b00;
            repeat (12) @(posedge clk_i);
            cmp_bits("held", 2'b11, irq_req_o);
            wr(IQ, 8'h00);
            repeat (8) @(posedge clk_i);
            cmp_bits("cleared", 2'b00, irq_req_o);
        end
        wr(FL, 8'h01);
        wr(RS, 8'h00);
        wr(IQ, 8'h00);
        act <= 2'b11;
        repeat (12) @(posedge clk_i);
        irq_ack_i <= 2'b11;
        @(posedge clk_i);
        irq_ack_i <= 2'b00;
        repeat (6) @(posedge clk_i);
        cmp_bits("acked", 2'b01, irq_req_o);
        act <= 2'b00;
        repeat (10) @(posedge clk_i);
        wr(IQ, 8'h00);
        repeat (8) @(posedge clk_i);
        cmp_bits("dropped", 2'b00, irq_req_o);
        print_verdict();
    end
endmodule
bind apt_top apt_top_asserts #(.NPIN(NPIN)) apt_top_asserts_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .addr_bit_i, .irq_ack_i, .pin_i, .pin_o, .pin_oe_o, .irq_req_o
);
